// ### logic/dcs_dma_top.sv
// Peripheral DMA channel with drain-aligned completion and AXI4-Lite registers
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dcs_dma_top #(
   parameter int N_PERIPH   = dcs_pkg::NUM_PERIPH,
   parameter int FIFO_DEPTH = dcs_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // AXI4-Lite register slave
   input  wire logic [dcs_pkg::AXI_AW-1:0]    s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [dcs_pkg::AXI_AW-1:0]    s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   // System memory port
   output logic                               mem_req,
   output logic                               mem_we,
   output logic [31:0]                        mem_addr,
   output logic [31:0]                        mem_wdata,
   input  wire logic                          mem_ready,
   input  wire logic                          mem_rvalid,
   input  wire logic [31:0]                   mem_rdata,
   // Peripheral transmit stream
   output logic [31:0]                        tx_data,
   output logic [N_PERIPH-1:0]                tx_valid,
   input  wire logic [N_PERIPH-1:0]           tx_ready,
   // Peripheral receive stream
   input  wire logic [N_PERIPH-1:0][31:0]     rx_data,
   input  wire logic [N_PERIPH-1:0]           rx_valid,
   output logic [N_PERIPH-1:0]                rx_ready,
   // Shared interrupt
   output logic                               irq
);
   import dcs_pkg::*;

   if (N_PERIPH < 1 || N_PERIPH > (1 << PSEL_W)) begin : g_bad_periph
      $error("dcs_dma_top: N_PERIPH out of range");
   end

   typedef struct packed {
      dcs_state_t           st;
      logic [1:0]           fidx;
      logic                 pend;
      logic                 first;
      logic                 space;
      logic [31:0]          next_ptr;
      logic [31:0]          nnext;
      logic [31:0]          naddr;
      logic [31:0]          cur_addr;
      logic [15:0]          cfg;
      logic [15:0]          left;
      logic [15:0]          rx_left;
      logic [PSEL_W-1:0]    psel;
      logic [1:0]           stat;
      logic [1:0]           mask;
      logic                 aw_got;
      logic                 w_got;
      logic [AXI_AW-1:0]    awa;
      logic [31:0]          wd;
      logic [3:0]           ws;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [1:0]           rresp;
      logic [31:0]          rdata;
      logic                 mem_req;
      logic                 mem_we;
      logic [31:0]          mem_addr;
      logic [31:0]          mem_wdata;
   } dcs_regs_t;

   dcs_regs_t   r;
   dcs_regs_t   n;
   logic        is_tx;
   logic        prev_free;
   logic        run;
   logic        unit_done;
   logic        fetch_last;
   logic        cfg_err;
   logic        ev_done;
   logic        ev_err;
   logic        rx_ok;
   logic [15:0] ncfg;

   dcs_fifo_if #(.W(32)) f ();

   dcs_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
      .aclk    (aclk),
      .aresetn (aresetn),
      .fp      (f.store)
   );

   always_comb begin
      n          = r;
      unit_done  = 1'b0;
      ev_done    = 1'b0;
      ev_err     = 1'b0;
      cfg_err    = 1'b0;
      ncfg       = mem_rdata[15:0];
      is_tx      = !r.cfg[CFG_WNR];
      // Only a drain-aligned transmit unit frees the next unit's size and direction
      prev_free  = !r.cfg[CFG_WNR] && r.cfg[CFG_SYNC];
      run        = (r.st != ST_IDLE) || f.pop_valid;
      fetch_last = (r.st == ST_FETCH) && r.pend && mem_rvalid && (r.fidx == DESC_LAST);
      rx_ok      = (r.st == ST_XFER) && !is_tx && (r.rx_left != 16'h0) && f.push_ready;
      tx_valid   = '0;
      rx_ready   = '0;
      tx_valid[r.psel] = f.pop_valid && is_tx;
      rx_ready[r.psel] = rx_ok;
      f.push_valid = 1'b0;
      f.push_data  = is_tx ? mem_rdata : rx_data[r.psel];
      f.pop_ready  = is_tx && tx_ready[r.psel];
      s_axi_awready = !r.aw_got && !r.bvalid;
      s_axi_wready  = !r.w_got && !r.bvalid;
      s_axi_arready = !r.rvalid;

      // Register writes
      if (s_axi_awvalid && s_axi_awready) begin
         n.aw_got = 1'b1;
         n.awa    = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         n.w_got = 1'b1;
         n.wd    = s_axi_wdata;
         n.ws    = s_axi_wstrb;
      end
      if (r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (r.aw_got && r.w_got) begin
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = RESP_OKAY;
         case (r.awa)
            OFF_CTRL: begin
               if (r.ws[0] && r.wd[CTRL_START] && r.st == ST_IDLE) begin
                  n.st       = ST_FETCH;
                  n.fidx     = 2'h0;
                  n.first    = 1'b1;
                  n.mem_req  = 1'b1;
                  n.mem_we   = 1'b0;
                  n.mem_addr = r.next_ptr;
               end
            end
            OFF_NEXT: n.next_ptr = dcs_strb(r.next_ptr, r.wd, r.ws);
            OFF_ASSIGN: begin
               if (r.ws[0] && 32'(r.wd[PSEL_W-1:0]) < N_PERIPH) begin
                  n.psel = r.wd[PSEL_W-1:0];
               end
            end
            OFF_STAT: begin
               if (r.ws[0]) begin
                  n.stat = r.stat & ~r.wd[1:0];
               end
            end
            OFF_MASK: begin
               if (r.ws[0]) begin
                  n.mask = r.wd[1:0];
               end
            end
            OFF_ADDR, OFF_COUNT, OFF_CFG: begin
            end
            default: n.bresp = RESP_SLVERR;
         endcase
      end

      // Register reads
      if (r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         n.rvalid = 1'b1;
         n.rresp  = RESP_OKAY;
         case (s_axi_araddr)
            OFF_CTRL:   n.rdata = 32'h0;
            OFF_NEXT:   n.rdata = r.next_ptr;
            OFF_ASSIGN: n.rdata = {{(32-PSEL_W){1'b0}}, r.psel};
            OFF_STAT:   n.rdata = {29'h0, run, r.stat};
            OFF_MASK:   n.rdata = {30'h0, r.mask};
            OFF_ADDR:   n.rdata = r.cur_addr;
            OFF_COUNT:  n.rdata = {16'h0, r.left};
            OFF_CFG:    n.rdata = {16'h0, r.cfg};
            default: begin
               n.rdata = 32'h0;
               n.rresp = RESP_SLVERR;
            end
         endcase
      end

      // Memory handshake, one access outstanding
      if (r.mem_req && mem_ready) begin
         n.mem_req = 1'b0;
         n.pend    = !r.mem_we;
      end
      if (r.pend && mem_rvalid) begin
         n.pend = 1'b0;
      end

      unique case (r.st)
         ST_IDLE: begin
         end
         ST_FETCH: begin
            if (fetch_last) begin
               // Size and direction changes need a drain-aligned transmit predecessor; space changes into a transmit unit need a predecessor with CFG_SYNC set
               cfg_err = !r.first && (((ncfg[CFG_SIZE +: 2] != r.cfg[CFG_SIZE +: 2]
                         || ncfg[CFG_WNR] != r.cfg[CFG_WNR]) && !prev_free)
                         || (!ncfg[CFG_WNR] && r.naddr[SPACE_BIT] != r.space
                         && !r.cfg[CFG_SYNC]));
               if (cfg_err) begin
                  ev_err = 1'b1;
                  n.st   = ST_IDLE;
               end else begin
                  n.st       = ST_XFER;
                  n.first    = 1'b0;
                  n.cfg      = ncfg;
                  n.left     = mem_rdata[31:16];
                  n.rx_left  = mem_rdata[31:16];
                  n.cur_addr = r.naddr;
                  n.space    = r.naddr[SPACE_BIT];
                  n.next_ptr = r.nnext;
               end
            end else if (r.pend && mem_rvalid) begin
               if (r.fidx == 2'h0) begin
                  n.nnext = mem_rdata;
               end else begin
                  n.naddr = mem_rdata;
               end
               n.fidx     = r.fidx + 2'h1;
               n.mem_req  = 1'b1;
               n.mem_we   = 1'b0;
               n.mem_addr = r.next_ptr + {28'h0, n.fidx, 2'b00};
            end
         end
         ST_XFER: begin
            if (is_tx) begin
               f.push_valid = r.pend && mem_rvalid;
               if (r.left != 16'h0 && !r.pend && !r.mem_req && f.push_ready) begin
                  n.mem_req  = 1'b1;
                  n.mem_we   = 1'b0;
                  n.mem_addr = r.cur_addr;
                  n.cur_addr = r.cur_addr + dcs_stride(r.cfg[CFG_SIZE +: 2]);
                  n.left     = r.left - 16'h1;
               end else if (r.left == 16'h0 && !r.pend && !r.mem_req) begin
                  if (r.cfg[CFG_SYNC]) begin
                     n.st = ST_DRAIN;
                  end else begin
                     unit_done = 1'b1;
                  end
               end
            end else begin
               f.push_valid = rx_ok && rx_valid[r.psel];
               if (f.push_valid) begin
                  n.rx_left = r.rx_left - 16'h1;
               end
               if (!r.mem_req && f.pop_valid && r.left != 16'h0) begin
                  f.pop_ready = 1'b1;
                  n.mem_req   = 1'b1;
                  n.mem_we    = 1'b1;
                  n.mem_addr  = r.cur_addr;
                  n.mem_wdata = f.pop_data;
                  n.cur_addr  = r.cur_addr + dcs_stride(r.cfg[CFG_SIZE +: 2]);
                  n.left      = r.left - 16'h1;
               end else if (r.left == 16'h0 && !r.mem_req) begin
                  unit_done = 1'b1;
               end
            end
         end
         ST_DRAIN: begin
            unit_done = !f.pop_valid;
         end
      endcase

      if (unit_done) begin
         ev_done = r.cfg[CFG_IRQ_EN];
         if (r.cfg[CFG_FLOW +: 4] == FLOW_STOP) begin
            n.st = ST_IDLE;
         end else begin
            n.st       = ST_FETCH;
            n.fidx     = 2'h0;
            n.mem_req  = 1'b1;
            n.mem_we   = 1'b0;
            n.mem_addr = r.next_ptr;
         end
      end
      // New events win over a clear in the same cycle
      if (ev_done) begin
         n.stat[STAT_DONE] = 1'b1;
      end
      if (ev_err) begin
         n.stat[STAT_ERR] = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r          <= '0;
         r.st       <= ST_IDLE;
         r.psel     <= RST_PSEL;
         r.mask     <= RST_MASK;
         r.next_ptr <= RST_NEXT;
      end else begin
         r <= n;
      end
   end

   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp  = r.bresp;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rresp  = r.rresp;
   assign s_axi_rdata  = r.rdata;
   assign mem_req      = r.mem_req;
   assign mem_we       = r.mem_we;
   assign mem_addr     = r.mem_addr;
   assign mem_wdata    = r.mem_wdata;
   assign tx_data      = f.pop_data;
   assign irq          = |(r.stat & r.mask);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_assign_write: assert property ((r.aw_got && r.w_got && r.awa == OFF_ASSIGN && r.ws[0]
      && 32'(r.wd[PSEL_W-1:0]) < N_PERIPH) |=> r.psel == $past(r.wd[PSEL_W-1:0]))
      else $error("peripheral select not taken");
   chk_psel_range: assert property (32'(r.psel) < N_PERIPH)
      else $error("peripheral select out of range");
   chk_run_read: assert property ((s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_STAT
      && f.pop_valid) |=> s_axi_rdata[STAT_RUN])
      else $error("running flag low with data pending");
   chk_nosync_early: assert property ((r.st == ST_XFER && is_tx && !r.cfg[CFG_SYNC]
      && r.cfg[CFG_IRQ_EN] && r.left == 16'h0 && !r.pend && !r.mem_req) |=> r.stat[STAT_DONE])
      else $error("unaligned transmit interrupt late");
   chk_sync_drained: assert property ((unit_done && is_tx && r.cfg[CFG_SYNC]) |-> !f.pop_valid)
      else $error("aligned completion before FIFO empty");
   chk_stop_run: assert property ((unit_done && is_tx && r.cfg[CFG_SYNC]
      && r.cfg[CFG_FLOW +: 4] == FLOW_STOP) |=> !run)
      else $error("aligned stop interrupt while running");
   chk_stop_halt: assert property ((unit_done && r.cfg[CFG_FLOW +: 4] == FLOW_STOP) |=> r.st == ST_IDLE ##1 !r.mem_req)
      else $error("stop mode did not halt");
   chk_chain_fetch: assert property ((unit_done && r.cfg[CFG_FLOW +: 4] != FLOW_STOP)
      |=> (r.st == ST_FETCH && r.mem_req && r.mem_addr == $past(r.next_ptr)))
      else $error("next descriptor not fetched");
   chk_setting_lock: assert property (cfg_err |=> (r.st == ST_IDLE && r.stat[STAT_ERR]))
      else $error("locked setting change not refused");
   chk_aligned_free: assert property ((fetch_last && prev_free) |-> !cfg_err)
      else $error("aligned transmit refused a change");
   chk_irq_shared: assert property ((r.stat[STAT_ERR] && r.mask[STAT_ERR]) |-> irq)
      else $error("error event not on shared interrupt");

   cov_nosync_pending: cover property (unit_done && is_tx && !r.cfg[CFG_SYNC] && f.pop_valid);
   cov_sync_drain: cover property (r.st == ST_DRAIN ##1 unit_done);
   cov_cfg_error: cover property (cfg_err);
   cov_rx_done: cover property (unit_done && !is_tx);

endmodule : dcs_dma_top
`default_nettype wire

// ### logic/dcs_fifo.sv
// Channel data FIFO between memory and peripheral
`timescale 1ns/1ps
`default_nettype none
module dcs_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = dcs_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Storage side
   dcs_fifo_if.store fp
);
   import dcs_pkg::*;

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("dcs_fifo: DEPTH must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           rd;
      logic [PW-1:0]           wr;
      logic [CW-1:0]           cnt;
   } dcs_fifo_st_t;

   dcs_fifo_st_t r;
   dcs_fifo_st_t n;
   logic         push;
   logic         pop;

   always_comb begin
      n             = r;
      fp.push_ready = (r.cnt != CW'(DEPTH));
      fp.pop_valid  = (r.cnt != '0);
      fp.pop_data   = r.mem[r.rd];
      push          = fp.push_valid && fp.push_ready;
      pop           = fp.pop_ready && fp.pop_valid;
      // DEPTH-entry store with wrapping pointers
      if (push) begin
         n.mem[r.wr] = fp.push_data;
         n.wr        = r.wr + 1'b1;
      end
      if (pop) begin
         n.rd = r.rd + 1'b1;
      end
      n.cnt = r.cnt + CW'(push) - CW'(pop);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_fifo_bound: assert property (r.cnt <= CW'(DEPTH))
      else $error("fifo level above depth");
   chk_fifo_full_stall: assert property ((r.cnt == CW'(DEPTH) && !pop) |=> r.cnt == CW'(DEPTH))
      else $error("full fifo lost or gained a word without pop");

endmodule : dcs_fifo
`default_nettype wire

// ### shared/dcs_fifo_if.sv
// Push and pop handshake between the channel engine and its FIFO
`timescale 1ns/1ps
`default_nettype none
interface dcs_fifo_if #(parameter int W = 32);
   logic         push_valid;
   logic         push_ready;
   logic [W-1:0] push_data;
   logic         pop_valid;
   logic         pop_ready;
   logic [W-1:0] pop_data;

   modport store (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
   modport user  (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data);
endinterface : dcs_fifo_if
`default_nettype wire

// ### shared/dcs_pkg.sv
// Constants, types and helpers shared by the drain-aligned DMA channel
package dcs_pkg;

   // Sizes
   localparam int         AXI_AW     = 8;
   localparam int         NUM_PERIPH = 12;
   localparam int         FIFO_DEPTH = 4;
   localparam int         PSEL_W     = 4;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_NEXT   = 8'h04;
   localparam logic [7:0] OFF_ASSIGN = 8'h08;
   localparam logic [7:0] OFF_STAT   = 8'h0C;
   localparam logic [7:0] OFF_MASK   = 8'h10;
   localparam logic [7:0] OFF_ADDR   = 8'h14;
   localparam logic [7:0] OFF_COUNT  = 8'h18;
   localparam logic [7:0] OFF_CFG    = 8'h1C;

   // Field positions
   localparam int         CTRL_START = 0;
   localparam int         CFG_WNR    = 1;
   localparam int         CFG_SIZE   = 2;
   localparam int         CFG_IRQ_EN = 4;
   localparam int         CFG_SYNC   = 5;
   localparam int         CFG_FLOW   = 12;
   localparam int         SPACE_BIT  = 31;
   localparam int         STAT_DONE  = 0;
   localparam int         STAT_ERR   = 1;
   localparam int         STAT_RUN   = 2;

   // Codes and reset values
   localparam logic [3:0]  FLOW_STOP   = 4'h0;
   localparam logic [1:0]  DESC_LAST   = 2'h2;
   localparam logic [3:0]  RST_PSEL    = 4'h0;
   localparam logic [1:0]  RST_MASK    = 2'h0;
   localparam logic [31:0] RST_NEXT    = 32'h0;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_XFER, ST_DRAIN} dcs_state_t;

   // Address step for a transfer word size code
   function automatic logic [31:0] dcs_stride(input logic [1:0] size);
      dcs_stride = 32'h1 << size;
   endfunction : dcs_stride

   // Byte-lane merge of a write
   function automatic logic [31:0] dcs_strb(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  s);
      dcs_strb = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            dcs_strb[8*i +: 8] = nw[8*i +: 8];
         end
      end
   endfunction : dcs_strb

endpackage : dcs_pkg

// ### verif/dcs_mem_model.sv
// Memory and transmit peripheral model facing the DMA channel
`timescale 1ns/1ps
`default_nettype none
module dcs_mem_model (
   // Clock and reset
   input  wire logic                           aclk,
   input  wire logic                           aresetn,
   // Memory port
   input  wire logic                           mem_req,
   input  wire logic                           mem_we,
   input  wire logic [31:0]                    mem_addr,
   input  wire logic [31:0]                    mem_wdata,
   output logic                                mem_ready,
   output logic                                mem_rvalid,
   output logic [31:0]                         mem_rdata,
   // Peripheral side
   input  wire logic                           stall,
   output logic [dcs_pkg::NUM_PERIPH-1:0]      tx_ready
);
   logic [31:0] mem [0:63];
   logic        slow_r;
   // Accepts on every other cycle, so answers are both prompt and late
   assign mem_ready = mem_req & slow_r;
   // Peripheral takes no words while stall is high and one every cycle while it is low
   assign tx_ready  = stall ? '0 : '1;
   always @(posedge aclk) begin
      slow_r     <= !aresetn | ~slow_r;
      mem_rvalid <= aresetn & mem_req & mem_ready & !mem_we;
      // Read data turns to junk once its one valid cycle is over
      mem_rdata  <= (mem_req & mem_ready) ? mem[mem_addr[7:2]] : ~mem_rdata;
      if (mem_req && mem_ready && mem_we) begin
         mem[mem_addr[7:2]] <= mem_wdata;
      end
   end
endmodule : dcs_mem_model
`default_nettype wire

// ### verif/tb_top.sv
// Register-level testbench of the DMA channel
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dcs_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0, stall = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd;
   logic [1:0]  rr;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire logic   awready, wready, bvalid, arready, rvalid, irq, mem_req, mem_we;
   wire logic   mem_ready, mem_rvalid;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata, mem_addr, mem_wdata, mem_rdata, tx_data;
   wire logic [11:0] tx_valid, tx_ready, rx_ready;
   int          fails = 0, n_checks = 0, ntx = 0;
   logic [15:0] c1 [4] = '{16'h1008, 16'h1028, 16'h1008, 16'h1028};
   logic [15:0] c2 [4] = '{16'h0000, 16'h0000, 16'h0008, 16'h0008};
   logic [31:0] a2 [4] = '{32'h80, 32'h80, 32'h80000080, 32'h80000080};
   logic [31:0] er [4] = '{32'h2, 32'h0, 32'h2, 32'h0};
   logic [11:0] rxv = 12'h000;

   always #12.5 aclk = ~aclk;
   always @(posedge aclk) if (aresetn && tx_valid[11] && tx_ready[11]) ntx++;

   dcs_dma_top dcs_dma_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_data({12{32'h5A5A5A5A}}), .rx_valid(rxv), .rx_ready(rx_ready), .irq(irq));
   dcs_mem_model dcs_mem_model_i (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
      .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .stall(stall), .tx_ready(tx_ready));

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && k < 200);
      if (!bvalid) fails++;
      bready <= 1'b0;
   endtask : wr

   task rdr(input logic [7:0] a);
      int k;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && k < 200);
      if (!rvalid) fails++;
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask : rdr

   task wirq();
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 400) begin
         @(posedge aclk);
         k++;
      end
      if (irq !== 1'b1) fails++;
   endtask : wirq

   task run_low();
      int k;
      k = 0;
      do begin
         rdr(OFF_STAT);
         k++;
      end while (rd[STAT_RUN] !== 1'b0 && k < 60);
      if (rd[STAT_RUN] !== 1'b0) fails++;
   endtask : run_low

   task desc(input int i, input logic [31:0] nx, ad, input logic [15:0] cf);
      dcs_mem_model_i.mem[i]     = nx;
      dcs_mem_model_i.mem[i + 1] = ad;
      dcs_mem_model_i.mem[i + 2] = {16'h0003, cf};
   endtask : desc

   task results();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results

   initial begin
      #500000;
      fails++;
      results();
   end

   initial begin
      for (int i = 0; i < 8; i++) dcs_mem_model_i.mem[32 + i] = 32'hA0 + i;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(OFF_MASK);
      chk(rd, 32'h0);
      rdr(OFF_NEXT);
      chk(rd, 32'h0);
      wr(OFF_ASSIGN, 32'hB);
      rdr(OFF_ASSIGN);
      chk(rd, 32'hB);
      wr(OFF_ASSIGN, 32'hC);
      rdr(OFF_ASSIGN);
      chk(rd, 32'hB);
      rdr(8'h40);
      chk({30'h0, rr}, {30'h0, RESP_SLVERR});
      $display("test registers done");
      desc(16, 32'h0, 32'h80, 16'h0018);
      wr(OFF_MASK, 32'h3);
      wr(OFF_NEXT, 32'h40);
      wr(OFF_CTRL, 32'h1);
      wirq();
      chk(irq, 1'b1);
      rdr(OFF_STAT);
      chk(rd, 32'h5);
      chk(tx_valid, 12'h800);
      chk(tx_data, 32'hA0);
      stall <= 1'b0;
      run_low();
      chk(ntx, 3);
      wr(OFF_STAT, 32'h1);
      chk(irq, 1'b0);
      $display("test unaligned stop done");
      desc(16, 32'h0, 32'h80, 16'h0038);
      stall <= 1'b1;
      wr(OFF_NEXT, 32'h40);
      wr(OFF_CTRL, 32'h1);
      repeat (30) @(posedge aclk);
      chk(irq, 1'b0);
      rdr(OFF_STAT);
      chk(rd, 32'h4);
      stall <= 1'b0;
      wirq();
      rdr(OFF_STAT);
      chk(rd, 32'h1);
      chk(ntx, 6);
      wr(OFF_STAT, 32'h3);
      $display("test aligned stop done");
      rxv <= 12'hFFF;
      desc(16, 32'h0, 32'h90, 16'h003A);
      wr(OFF_NEXT, 32'h40);
      wr(OFF_CTRL, 32'h1);
      wirq();
      rdr(OFF_STAT);
      chk(rd, 32'h1);
      chk(dcs_mem_model_i.mem[38], 32'h5A5A5A5A);
      wr(OFF_STAT, 32'h1);
      $display("test receive done");
      for (int t = 0; t < 4; t++) begin
         desc(16, 32'h50, 32'h80, c1[t]);
         desc(20, 32'h0, a2[t], c2[t]);
         wr(OFF_NEXT, 32'h40);
         wr(OFF_CTRL, 32'h1);
         run_low();
         chk(rd & 32'h2, er[t]);
         wr(OFF_STAT, 32'h3);
      end
      $display("test chain settings done");
      results();
   end
endmodule : tb_top
`default_nettype wire
